// *** hw/dtp_pkg.sv ***
// Shared constants and types for the dual test access port
package dtp_pkg;

  // Instruction register widths, data register sizes
  localparam int            BS_IR_W        = 4;
  localparam int            DBG_IR_W       = 5;
  localparam int            BS_LEN         = 8;
  localparam int            DR_W           = 32;
  localparam int            SYNC_STAGES    = 2;

  // Boundary-scan controller instructions
  localparam logic [3:0]    BS_IR_EXTEST   = 4'h0;
  localparam logic [3:0]    BS_IR_SAMPLE   = 4'h1;
  localparam logic [3:0]    BS_IR_IDCODE   = 4'h2;
  localparam logic [3:0]    BS_IR_BYPASS   = 4'hf;

  // Debug controller instructions
  localparam logic [4:0]    DBG_IR_IDCODE  = 5'h01;
  localparam logic [4:0]    DBG_IR_CONTROL = 5'h0a;
  localparam logic [4:0]    DBG_IR_BYPASS  = 5'h1f;

  // Identification words: values are arbitrary
  localparam logic [31:0]   BS_IDCODE      = 32'h0000_a001;
  localparam logic [31:0]   DBG_IDCODE     = 32'h0000_b001;

  // Fixed low bits captured into an instruction register
  localparam logic [1:0]    IR_CAPTURE     = 2'h1;
  localparam logic [7:0]    BS_UPDATE_RST  = 8'h00;
  localparam logic [31:0]   DBG_CTRL_RST   = 32'h0000_0000;

  // Sampling limits: test clock must be far slower than mclk
  localparam int            MCLK_PERIOD_NS = 100;
  localparam int            TCK_PERIOD_NS  = 800;
  localparam int            TCK_HALF_CYC   = TCK_PERIOD_NS / 2 / MCLK_PERIOD_NS;

  typedef enum logic [15:0] {
    TAP_RESET    = 16'h0001,
    TAP_IDLE     = 16'h0002,
    TAP_SEL_DR   = 16'h0004,
    TAP_CAP_DR   = 16'h0008,
    TAP_SHIFT_DR = 16'h0010,
    TAP_EXIT1_DR = 16'h0020,
    TAP_PAUSE_DR = 16'h0040,
    TAP_EXIT2_DR = 16'h0080,
    TAP_UPD_DR   = 16'h0100,
    TAP_SEL_IR   = 16'h0200,
    TAP_CAP_IR   = 16'h0400,
    TAP_SHIFT_IR = 16'h0800,
    TAP_EXIT1_IR = 16'h1000,
    TAP_PAUSE_IR = 16'h2000,
    TAP_EXIT2_IR = 16'h4000,
    TAP_UPD_IR   = 16'h8000
  } dtp_tap_state_type;

  // Test pins after the two-stage synchroniser
  typedef struct packed {
    logic tck;
    logic tdi;
    logic bsTms;
    logic dbgTms;
  } dtp_pins_type;

endpackage : dtp_pkg

// *** hw/dtp_tap_fsm.sv ***
// Sixteen-state test access controller sequencer
`timescale 1ns/10ps
module dtp_tap_fsm
  import dtp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              srst,
  input  wire logic              tapResetN,
  input  wire logic              tckRise,
  input  wire logic              tms,
  output dtp_tap_state_type      state
);

  dtp_tap_state_type state_reg;
  dtp_tap_state_type state_next;

  // Moves on a rising test clock edge; srst forces the reset state without one
  always_comb begin
    state_next = state_reg;
    if (srst) begin
      state_next = TAP_RESET;
    end else if (tckRise) begin
      case (state_reg)
        TAP_RESET:    state_next = tms ? TAP_RESET    : TAP_IDLE;
        TAP_IDLE:     state_next = tms ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_DR:   state_next = tms ? TAP_SEL_IR   : TAP_CAP_DR;
        TAP_CAP_DR:   state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: state_next = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
        TAP_PAUSE_DR: state_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: state_next = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
        TAP_UPD_DR:   state_next = tms ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_IR:   state_next = tms ? TAP_RESET    : TAP_CAP_IR;
        TAP_CAP_IR:   state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: state_next = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
        TAP_PAUSE_IR: state_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: state_next = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
        TAP_UPD_IR:   state_next = tms ? TAP_SEL_DR   : TAP_IDLE;
        default:      state_next = TAP_RESET;
      endcase
    end
  end

  // Test reset forces the sequencer home regardless of the test clock
  always_ff @(posedge mclk or negedge tapResetN) begin
    if (!tapResetN) begin
      state_reg <= TAP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state = state_reg;

endmodule : dtp_tap_fsm

// *** hw/dtp_test_port.sv ***
// Dual test access port: boundary-scan and debug controllers on shared pins
`timescale 1ns/10ps

// Functional notes
// [RULE_01] Low test reset asynchronously resets both controllers and scan logic.
// [RULE_02] Debug mode-select drives only the debug controller.
// [RULE_03] Debug mode-select is pulled high when nothing drives it.
// [RULE_04] Tester keeps debug mode-select high during boundary-scan work.
// [RULE_05] In functional use test reset is held low or mode-select held high.
// [RULE_06] Test clock times all shifting, independent of system clocks, half duty. Here it is sampled on mclk and must be far slower.
// [RULE_07] Data out shows the shifting controller, else is high impedance.
// [RULE_08] One shared data input feeds both controllers and scan logic.
// [RULE_09] Boundary-scan mode-select drives the scan controller; high during debug.
// [RULE_10] Sixteen-state sequencers; mode-select on rising, data out on falling edge.
module dtp_test_port
  import dtp_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic                 testResetN,
  input  wire logic                 testClock,
  input  wire logic                 testDataIn,
  input  wire logic                 scanTapModeSelect,
  input  wire logic                 debugTapModeSelect,
  input  wire logic                 debugTapModeSelectDriven,
  input  wire logic [BS_LEN-1:0]    scanCaptureData,
  input  wire logic [DR_W-1:0]      debugStatus,
  output logic                      testDataOut,
  output logic                      testDataOutOe,
  output logic [BS_LEN-1:0]         scanUpdateData,
  output logic                      scanExtest,
  output logic [DR_W-1:0]           debugControl
);

  dtp_pins_type              pinsRaw;
  dtp_pins_type              pinsMeta_reg;
  dtp_pins_type              pinsSync_reg;
  logic                      tckPrev_reg;
  logic [SYNC_STAGES-1:0]    trstSync_reg;
  logic [SYNC_STAGES-1:0]    trstSync_next;
  logic                      tapResetN;
  logic                      tckRise;
  logic                      tckFall;
  dtp_tap_state_type         bsState;
  dtp_tap_state_type         dbgState;

  logic [BS_IR_W-1:0]        bsIr_reg;
  logic [BS_IR_W-1:0]        bsIr_next;
  logic [BS_IR_W-1:0]        bsIrSh_reg;
  logic [BS_IR_W-1:0]        bsIrSh_next;
  logic [DR_W-1:0]           bsDr_reg;
  logic [DR_W-1:0]           bsDr_next;
  logic [BS_LEN-1:0]         scanUpdateData_reg;
  logic [BS_LEN-1:0]         scanUpdateData_next;
  logic                      scanExtest_reg;
  logic                      scanExtest_next;

  logic [DBG_IR_W-1:0]       dbgIr_reg;
  logic [DBG_IR_W-1:0]       dbgIr_next;
  logic [DBG_IR_W-1:0]       dbgIrSh_reg;
  logic [DBG_IR_W-1:0]       dbgIrSh_next;
  logic [DR_W-1:0]           dbgDr_reg;
  logic [DR_W-1:0]           dbgDr_next;
  logic [DR_W-1:0]           debugControl_reg;
  logic [DR_W-1:0]           debugControl_next;

  logic                      testDataOut_reg;
  logic                      testDataOut_next;
  logic                      testDataOutOe_reg;
  logic                      testDataOutOe_next;

  // Pad pull-up: an undriven debug mode-select reads as one
  always_comb begin
    pinsRaw.tck    = testClock;                                         // [RULE_06]
    pinsRaw.tdi    = testDataIn;                                        // [RULE_08]
    pinsRaw.bsTms  = scanTapModeSelect;                                 // [RULE_09]
    pinsRaw.dbgTms = debugTapModeSelectDriven ? debugTapModeSelect : 1'b1; // [RULE_03]
  end

  // Two-stage synchroniser; the test clock is just another sampled pin
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinsMeta_reg <= '0;
      pinsSync_reg <= '0;
      tckPrev_reg  <= 1'b0;
    end else begin
      pinsMeta_reg <= pinsRaw;
      pinsSync_reg <= pinsMeta_reg;
      tckPrev_reg  <= pinsSync_reg.tck;
    end
  end

  assign tckRise = pinsSync_reg.tck & ~tckPrev_reg;                   // [RULE_06]
  assign tckFall = ~pinsSync_reg.tck & tckPrev_reg;                   // [RULE_10]

  // Reset asserts at once, releases on mclk to avoid a ragged release
  assign trstSync_next = {trstSync_reg[SYNC_STAGES-2:0], 1'b1};

  always_ff @(posedge mclk or negedge testResetN) begin
    if (!testResetN) begin
      trstSync_reg <= '0;                                               // [RULE_01]
    end else begin
      trstSync_reg <= trstSync_next;
    end
  end

  assign tapResetN = trstSync_reg[SYNC_STAGES-1];

  dtp_tap_fsm u_bs_fsm (
    .mclk      (mclk),
    .srst      (srst),
    .tapResetN (tapResetN),
    .tckRise   (tckRise),
    .tms       (pinsSync_reg.bsTms),                                    // [RULE_09]
    .state     (bsState)
  );

  dtp_tap_fsm u_dbg_fsm (
    .mclk      (mclk),
    .srst      (srst),
    .tapResetN (tapResetN),
    .tckRise   (tckRise),
    .tms       (pinsSync_reg.dbgTms),                                   // [RULE_02]
    .state     (dbgState)
  );

  // Boundary-scan controller registers, acting on rising test clock, except scanExtest, which follows bsIr_reg on every mclk
  always_comb begin
    bsIr_next           = bsIr_reg;
    bsIrSh_next         = bsIrSh_reg;
    bsDr_next           = bsDr_reg;
    scanUpdateData_next = scanUpdateData_reg;
    scanExtest_next     = (bsIr_reg == BS_IR_EXTEST);
    if (srst) begin
      bsIr_next           = BS_IR_IDCODE;
      bsIrSh_next         = '0;
      bsDr_next           = '0;
      scanUpdateData_next = BS_UPDATE_RST;
      scanExtest_next     = 1'b0;
    end else if (tckRise) begin                                         // [RULE_10]
      case (bsState)
        TAP_RESET:    bsIr_next = BS_IR_IDCODE;
        TAP_CAP_IR:   bsIrSh_next = {{(BS_IR_W-2){1'b0}}, IR_CAPTURE};
        TAP_SHIFT_IR: bsIrSh_next = {pinsSync_reg.tdi, bsIrSh_reg[BS_IR_W-1:1]}; // [RULE_08]
        TAP_UPD_IR:   bsIr_next = bsIrSh_reg;
        TAP_CAP_DR: begin
          case (bsIr_reg)
            BS_IR_EXTEST, BS_IR_SAMPLE: bsDr_next = {{(DR_W-BS_LEN){1'b0}}, scanCaptureData};
            BS_IR_IDCODE:               bsDr_next = BS_IDCODE;
            default:                    bsDr_next = '0;
          endcase
        end
        TAP_SHIFT_DR: begin
          case (bsIr_reg)
            BS_IR_EXTEST, BS_IR_SAMPLE: begin
              bsDr_next = {{(DR_W-BS_LEN){1'b0}}, pinsSync_reg.tdi, bsDr_reg[BS_LEN-1:1]};
            end
            BS_IR_IDCODE: bsDr_next = {pinsSync_reg.tdi, bsDr_reg[DR_W-1:1]};
            default:      bsDr_next = {{(DR_W-1){1'b0}}, pinsSync_reg.tdi};
          endcase
        end
        TAP_UPD_DR: begin
          if (bsIr_reg == BS_IR_EXTEST || bsIr_reg == BS_IR_SAMPLE) begin
            scanUpdateData_next = bsDr_reg[BS_LEN-1:0];
          end
        end
        default: bsIr_next = bsIr_reg;
      endcase
    end
  end

  // Debug controller registers, same timing
  always_comb begin
    dbgIr_next        = dbgIr_reg;
    dbgIrSh_next      = dbgIrSh_reg;
    dbgDr_next        = dbgDr_reg;
    debugControl_next = debugControl_reg;
    if (srst) begin
      dbgIr_next        = DBG_IR_IDCODE;
      dbgIrSh_next      = '0;
      dbgDr_next        = '0;
      debugControl_next = DBG_CTRL_RST;
    end else if (tckRise) begin                                         // [RULE_10]
      case (dbgState)
        TAP_RESET:    dbgIr_next = DBG_IR_IDCODE;
        TAP_CAP_IR:   dbgIrSh_next = {{(DBG_IR_W-2){1'b0}}, IR_CAPTURE};
        TAP_SHIFT_IR: dbgIrSh_next = {pinsSync_reg.tdi, dbgIrSh_reg[DBG_IR_W-1:1]}; // [RULE_08]
        TAP_UPD_IR:   dbgIr_next = dbgIrSh_reg;
        TAP_CAP_DR: begin
          case (dbgIr_reg)
            DBG_IR_IDCODE:  dbgDr_next = DBG_IDCODE;
            DBG_IR_CONTROL: dbgDr_next = debugStatus;
            default:        dbgDr_next = '0;
          endcase
        end
        TAP_SHIFT_DR: begin
          if (dbgIr_reg == DBG_IR_IDCODE || dbgIr_reg == DBG_IR_CONTROL) begin
            dbgDr_next = {pinsSync_reg.tdi, dbgDr_reg[DR_W-1:1]};
          end else begin
            dbgDr_next = {{(DR_W-1){1'b0}}, pinsSync_reg.tdi};
          end
        end
        TAP_UPD_DR: begin
          if (dbgIr_reg == DBG_IR_CONTROL) begin
            debugControl_next = dbgDr_reg;
          end
        end
        default: dbgIr_next = dbgIr_reg;
      endcase
    end
  end

  // Data out changes on the falling edge; scan controller wins if both shift
  always_comb begin
    testDataOut_next   = testDataOut_reg;
    testDataOutOe_next = testDataOutOe_reg;
    if (srst) begin
      testDataOut_next   = 1'b0;
      testDataOutOe_next = 1'b0;
    end else if (tckFall) begin                                         // [RULE_10]
      testDataOutOe_next = 1'b1;
      case (1'b1)
        bsState == TAP_SHIFT_IR:  testDataOut_next = bsIrSh_reg[0];    // [RULE_07]
        bsState == TAP_SHIFT_DR:  testDataOut_next = bsDr_reg[0];
        dbgState == TAP_SHIFT_IR: testDataOut_next = dbgIrSh_reg[0];
        dbgState == TAP_SHIFT_DR: testDataOut_next = dbgDr_reg[0];
        default: begin
          testDataOut_next   = 1'b0;
          testDataOutOe_next = 1'b0;                                    // [RULE_07]
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge tapResetN) begin
    if (!tapResetN) begin                                               // [RULE_01]
      bsIr_reg           <= BS_IR_IDCODE;
      bsIrSh_reg         <= '0;
      bsDr_reg           <= '0;
      scanUpdateData_reg <= BS_UPDATE_RST;
      scanExtest_reg     <= 1'b0;
      dbgIr_reg          <= DBG_IR_IDCODE;
      dbgIrSh_reg        <= '0;
      dbgDr_reg          <= '0;
      debugControl_reg   <= DBG_CTRL_RST;
      testDataOut_reg    <= 1'b0;
      testDataOutOe_reg  <= 1'b0;
    end else begin
      bsIr_reg           <= bsIr_next;
      bsIrSh_reg         <= bsIrSh_next;
      bsDr_reg           <= bsDr_next;
      scanUpdateData_reg <= scanUpdateData_next;
      scanExtest_reg     <= scanExtest_next;
      dbgIr_reg          <= dbgIr_next;
      dbgIrSh_reg        <= dbgIrSh_next;
      dbgDr_reg          <= dbgDr_next;
      debugControl_reg   <= debugControl_next;
      testDataOut_reg    <= testDataOut_next;
      testDataOutOe_reg  <= testDataOutOe_next;
    end
  end

  assign testDataOut    = testDataOut_reg;
  assign testDataOutOe  = testDataOutOe_reg;
  assign scanUpdateData = scanUpdateData_reg;
  assign scanExtest     = scanExtest_reg;
  assign debugControl   = debugControl_reg;

endmodule : dtp_test_port

// *** verif/dtp_tester.sv ***
// Tester model driving the test pins from outside the device
`timescale 1ns/10ps
module dtp_tester
  import dtp_pkg::*;
(
  input  wire logic mclk,
  input  wire logic testDataOut,
  input  wire logic testDataOutOe,
  output logic      testClock,
  output logic      testResetN,
  output logic      testDataIn,
  output logic      scanTapModeSelect,
  output logic      debugTapModeSelect,
  output logic      debugTapModeSelectDriven
);
  logic floatDbg;

  // Controllers held in reset until the bench lets go
  initial begin
    testClock = 1'b0;
    testResetN = 1'b0;
    testDataIn = 1'b0;
    scanTapModeSelect = 1'b1;
    debugTapModeSelect = 1'b1;
    floatDbg = 1'b0;
  end
  assign debugTapModeSelectDriven = ~floatDbg;

  task automatic set_reset_n(input logic v);
    testResetN = v;
  endtask : set_reset_n

  // High leaves the debug pin to the pad pull-up
  task automatic set_float(input logic v);
    floatDbg = v;
  endtask : set_float

  // One clock of 800 ns, half duty; pins change only after the fall
  task automatic tick(input logic sTms, input logic dTms, input logic di,
                      output logic bo, output logic oe);
    scanTapModeSelect = sTms;
    debugTapModeSelect = dTms;
    testDataIn = di;
    repeat (TCK_HALF_CYC) @(posedge mclk);
    #1 testClock = 1'b1;
    repeat (TCK_HALF_CYC / 2) @(posedge mclk);
    #1 bo = testDataOut;
    oe = testDataOutOe;
    repeat (TCK_HALF_CYC / 2) @(posedge mclk);
    #1 testClock = 1'b0;
  endtask : tick

  // The idle controller sees its mode-select high all along
  task automatic step(input logic dbg, input logic t, input logic di,
                      output logic bo, output logic oe);
    tick(dbg ? 1'b1 : t, dbg ? t : 1'b1, di, bo, oe);
  endtask : step

  // Idle, select, capture, shift n bits LSB first, update, idle
  task automatic scan(input logic dbg, input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output int oeCnt);
    logic bo;
    logic oe;
    dout = '0;
    oeCnt = 0;
    step(dbg, 1'b0, 1'b0, bo, oe);
    step(dbg, 1'b1, 1'b0, bo, oe);
    if (ir) step(dbg, 1'b1, 1'b0, bo, oe);
    step(dbg, 1'b0, 1'b0, bo, oe);
    step(dbg, 1'b0, 1'b0, bo, oe);
    for (int i = 0; i < n; i++) begin
      step(dbg, i == n - 1, din[i], bo, oe);
      dout[i] = bo;
      if (oe === 1'b1) oeCnt++;
    end
    step(dbg, 1'b1, 1'b0, bo, oe);
    step(dbg, 1'b0, 1'b0, bo, oe);
  endtask : scan
endmodule : dtp_tester

// *** verif/dtp_test_port_properties.sv ***
// Pin-level checks of the dual test access port
`timescale 1ns/10ps
module dtp_test_port_properties
  import dtp_pkg::*;
(
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              testResetN,
  input wire logic              testClock,
  input wire logic              testDataIn,
  input wire logic              scanTapModeSelect,
  input wire logic              debugTapModeSelect,
  input wire logic              debugTapModeSelectDriven,
  input wire logic [BS_LEN-1:0] scanCaptureData,
  input wire logic [DR_W-1:0]   debugStatus,
  input wire logic              testDataOut,
  input wire logic              testDataOutOe,
  input wire logic [BS_LEN-1:0] scanUpdateData,
  input wire logic              scanExtest,
  input wire logic [DR_W-1:0]   debugControl
);
  logic       tckPrev;
  logic [6:0] fallHist;
  logic [6:0] riseHist;
  logic [3:0] idleCnt;

  // Raw edge history; the design lags it by its synchroniser
  always_ff @(posedge mclk) begin
    tckPrev  <= testClock;
    fallHist <= {fallHist[5:0], tckPrev & ~testClock};
    riseHist <= {riseHist[5:0], ~tckPrev & testClock};
    idleCnt  <= (srst || tckPrev != testClock) ? 4'h0 : idleCnt + {3'h0, idleCnt != 4'hf};
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  sequence srst_held;
    srst ##1 srst;
  endsequence
  sequence trst_release;
    !testResetN ##1 testResetN;
  endsequence

  rst_zero_a: assert property (!testResetN |-> !testDataOutOe && debugControl == '0 &&
    scanUpdateData == '0 && !scanExtest) else $error("outputs not cleared by test reset");
  srst_zero_a: assert property (disable iff (!testResetN) srst_held |->
    !testDataOutOe && debugControl == '0) else $error("outputs not cleared by srst");
  rel_hold_a: assert property (trst_release |->
    !testDataOutOe && scanUpdateData == '0)
    else $error("reset release not synchronised");
  oe_timing_a: assert property (disable iff (srst || !testResetN)
    $changed(testDataOutOe) |-> |fallHist[5:1]) else $error("enable moved off a clock fall");
  tdo_timing_a: assert property (disable iff (srst || !testResetN)
    $changed(testDataOut) |-> |fallHist[5:1]) else $error("data out moved off a clock fall");
  ctrl_timing_a: assert property (disable iff (srst || !testResetN)
    $changed(debugControl) |-> |riseHist[5:1]) else $error("control moved off a clock rise");
  scan_upd_a: assert property (disable iff (srst || !testResetN)
    $changed(scanUpdateData) |-> |riseHist[5:1]) else $error("scan latch moved off a rise");
  extest_timing_a: assert property (disable iff (srst || !testResetN)
    $changed(scanExtest) |-> |riseHist[6:1]) else $error("extest moved off a clock rise");
  idle_stable_a: assert property (disable iff (srst || !testResetN)
    idleCnt >= 4'h8 |->
    $stable({testDataOut, testDataOutOe, scanUpdateData, scanExtest, debugControl}))
    else $error("outputs moved while test clock idle");
endmodule : dtp_test_port_properties

bind dtp_test_port dtp_test_port_properties chk (.mclk(mclk), .srst(srst),
  .testResetN(testResetN), .testClock(testClock), .testDataIn(testDataIn),
  .scanTapModeSelect(scanTapModeSelect), .debugTapModeSelect(debugTapModeSelect),
  .debugTapModeSelectDriven(debugTapModeSelectDriven), .scanCaptureData(scanCaptureData),
  .debugStatus(debugStatus), .testDataOut(testDataOut), .testDataOutOe(testDataOutOe),
  .scanUpdateData(scanUpdateData), .scanExtest(scanExtest), .debugControl(debugControl));

// *** verif/testbench.sv ***
// Self-checking bench for the dual test access port
`timescale 1ns/10ps
module testbench
  import dtp_pkg::*;
;
  logic              mclk, srst, testResetN, testClock, testDataIn;
  logic              scanTapModeSelect, debugTapModeSelect, debugTapModeSelectDriven;
  logic [BS_LEN-1:0] scanCaptureData, scanUpdateData;
  logic [DR_W-1:0]   debugStatus, debugControl, d;
  logic              testDataOut, testDataOutOe, scanExtest;
  int                fails, n_checks, cycles, oeN;

  dtp_test_port dut (.mclk(mclk), .srst(srst), .testResetN(testResetN),
    .testClock(testClock), .testDataIn(testDataIn), .scanTapModeSelect(scanTapModeSelect),
    .debugTapModeSelect(debugTapModeSelect), .debugTapModeSelectDriven(debugTapModeSelectDriven),
    .scanCaptureData(scanCaptureData), .debugStatus(debugStatus), .testDataOut(testDataOut),
    .testDataOutOe(testDataOutOe), .scanUpdateData(scanUpdateData), .scanExtest(scanExtest),
    .debugControl(debugControl));
  dtp_tester tst (.mclk(mclk), .testDataOut(testDataOut), .testDataOutOe(testDataOutOe),
    .testClock(testClock), .testResetN(testResetN), .testDataIn(testDataIn),
    .scanTapModeSelect(scanTapModeSelect), .debugTapModeSelect(debugTapModeSelect),
    .debugTapModeSelectDriven(debugTapModeSelectDriven));

  task automatic tally_and_finish;
    if (fails == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic zero_chk;
    chk("oe", 32'h0, {31'h0, testDataOutOe});
    chk("ctrl", 32'h0, debugControl);
    chk("upd extest", 32'h0, {23'h0, scanExtest, scanUpdateData});
  endtask : zero_chk

  task automatic t_ids;
    tst.scan(1'b0, 1'b0, 32, 32'h0, d, oeN);
    chk("scan id", BS_IDCODE, d);
    chk("shift oe", 32'd32, 32'(oeN));
    chk("idle oe", 32'h0, {31'h0, testDataOutOe});
    tst.scan(1'b1, 1'b0, 32, 32'h0, d, oeN);
    chk("debug id", DBG_IDCODE, d);
  endtask : t_ids

  task automatic t_dbg_ctrl;
    debugStatus = 32'h1234_abcd;
    tst.scan(1'b1, 1'b1, 5, {27'h0, DBG_IR_CONTROL}, d, oeN);
    chk("ir capture", {30'h0, IR_CAPTURE}, {30'h0, d[1:0]});
    tst.scan(1'b1, 1'b0, 32, 32'h5a5a_c3c3, d, oeN);
    chk("dbg capture", 32'h1234_abcd, d);
    chk("dbg ctrl", 32'h5a5a_c3c3, debugControl);
    chk("scan untouched", 32'h0, {24'h0, scanUpdateData});
  endtask : t_dbg_ctrl

  task automatic t_extest;
    scanCaptureData = 8'h3c;
    tst.scan(1'b0, 1'b1, 4, {28'h0, BS_IR_EXTEST}, d, oeN);
    chk("extest on", 32'h1, {31'h0, scanExtest});
    tst.scan(1'b0, 1'b0, 8, 32'h0000_00a5, d, oeN);
    chk("scan capture", 32'h3c, {24'h0, d[7:0]});
    chk("scan upd", 32'ha5, {24'h0, scanUpdateData});
    chk("ctrl kept", 32'h5a5a_c3c3, debugControl);
    tst.scan(1'b0, 1'b1, 4, {28'h0, BS_IR_BYPASS}, d, oeN);
    chk("extest off", 32'h0, {31'h0, scanExtest});
    tst.scan(1'b0, 1'b0, 2, 32'h1, d, oeN);
    chk("bypass", 32'h2, {30'h0, d[1:0]});
  endtask : t_extest

  // Undriven debug pin reads high, so this write must not land
  task automatic t_pullup;
    tst.set_float(1'b1);
    tst.scan(1'b1, 1'b1, 5, {27'h0, DBG_IR_CONTROL}, d, oeN);
    tst.scan(1'b1, 1'b0, 32, 32'h0, d, oeN);
    chk("float oe", 32'h0, 32'(oeN));
    chk("float ctrl", 32'h5a5a_c3c3, debugControl);
    tst.set_float(1'b0);
  endtask : t_pullup

  task automatic t_trst;
    logic bo;
    logic oe;
    @(posedge mclk);
    #1 tst.set_reset_n(1'b0);
    #1 zero_chk();
    @(posedge mclk);
    #1 tst.tick(1'b1, 1'b1, 1'b0, bo, oe);
    tst.tick(1'b1, 1'b1, 1'b1, bo, oe);
    zero_chk();
    @(posedge mclk);
    #1 tst.set_reset_n(1'b1);
    repeat (4) @(posedge mclk);
    #1 tst.scan(1'b1, 1'b0, 32, 32'h0, d, oeN);
    chk("id after reset", DBG_IDCODE, d);
  endtask : t_trst

  // Mid-run system reset must wipe a fresh debug write, not just reset values
  task automatic t_srst;
    t_dbg_ctrl();
    @(posedge mclk);
    #1 srst = 1'b1;
    repeat (3) @(posedge mclk);
    #1 srst = 1'b0;
    zero_chk();
    repeat (4) @(posedge mclk);
    #1 tst.scan(1'b1, 1'b0, 32, 32'h0, d, oeN);
    chk("id after srst", DBG_IDCODE, d);
  endtask : t_srst

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Whole run needs about 2800 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    srst = 1'b1;
    scanCaptureData = 8'h00;
    debugStatus = 32'h0;
    repeat (10) @(posedge mclk);
    #1 srst = 1'b0;
    zero_chk();
    tst.set_reset_n(1'b1);
    repeat (4) @(posedge mclk);
    #1 t_ids();
    t_dbg_ctrl();
    t_extest();
    t_pullup();
    t_trst();
    t_srst();
    tally_and_finish();
  end
endmodule : testbench
